// File: src/msec_pkg.sv
// Package for the memory error-correcting checker: widths, flash operation
// codes and the shared check-bit arithmetic.
// Assumes a single synchronous clock domain; it holds no logic of its own.
package msec_pkg;

    // ------------------------------------------------------------------
    // Widths and defaults
    // ------------------------------------------------------------------
    localparam int DATA_W       = 64;
    localparam int HAM_W        = 7;
    localparam int CHK_W        = 8;
    localparam int FOLD_W       = 16;
    localparam int SRAM_AW_DEF  = 8;
    localparam int FLASH_AW_DEF = 10;
    localparam int SECT_W_DEF   = 2;

    localparam logic [DATA_W-1:0] ERASED_WORD = 64'hFFFF_FFFF_FFFF_FFFF;

    // ------------------------------------------------------------------
    // Flash operation codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MSEC_OP_READ    = 2'b00,
        MSEC_OP_PROGRAM = 2'b01,
        MSEC_OP_ERASE   = 2'b10,
        MSEC_OP_NONE    = 2'b11
    } msec_op_t;

    // ------------------------------------------------------------------
    // Check-bit arithmetic
    // ------------------------------------------------------------------
    // Position of payload bit idx in the Hamming code word: the idx-th
    // position from 3 upward that is not a power of two.
    function automatic logic [HAM_W-1:0] msec_pos(input int idx);
        int n;
        logic [HAM_W-1:0] res;
        n   = 0;
        res = '0;
        for (int p = 3; p < 128; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (n == idx) begin
                    res = HAM_W'(p);
                end
                n++;
            end
        end
        return res;
    endfunction

    // Hamming part over the data word and the folded address bits.
    function automatic logic [HAM_W-1:0] msec_hamming(input logic [DATA_W-1:0] d,
                                                      input logic [FOLD_W-1:0] a);
        logic [HAM_W-1:0] h;
        h = '0;
        for (int i = 0; i < DATA_W; i++) begin
            if (d[i]) begin
                h = h ^ msec_pos(i);
            end
        end
        for (int j = 0; j < FOLD_W; j++) begin
            if (a[j]) begin
                h = h ^ msec_pos(DATA_W + j);
            end
        end
        return h;
    endfunction

    // Full check byte: overall parity on top of the Hamming part.
    function automatic logic [CHK_W-1:0] msec_encode(input logic [DATA_W-1:0] d,
                                                     input logic [FOLD_W-1:0] a);
        logic [HAM_W-1:0] h;
        h = msec_hamming(d, a);
        return {^{d, a, h}, h};
    endfunction

endpackage

// File: src/msec_secded.sv
// Single-error-correct, double-error-detect decoder for one 64-bit word.
// Purely combinational; the caller registers its results.
`timescale 1ns/1ns
module msec_secded
    import msec_pkg::*;
(
    input  wire logic [msec_pkg::DATA_W-1:0] data_in,
    input  wire logic [msec_pkg::FOLD_W-1:0] fold_addr,
    input  wire logic [msec_pkg::CHK_W-1:0]  chk_in,
    output logic      [msec_pkg::DATA_W-1:0] data_fix,
    output logic                             err_single,
    output logic                             err_double
);

    logic [HAM_W-1:0] syn;
    logic             par;
    logic             addr_hit;

    always_comb begin
        syn      = msec_hamming(data_in, fold_addr) ^ chk_in[HAM_W-1:0];
        par      = ^{data_in, fold_addr, chk_in};
        addr_hit = 1'b0;
        data_fix = data_in;
        // An address position in the syndrome means the word came from the
        // wrong location, so it is never "corrected" into looking good.
        for (int j = 0; j < FOLD_W; j++) begin
            if (par && syn == msec_pos(DATA_W + j)) begin
                addr_hit = 1'b1;
            end
        end
        for (int i = 0; i < DATA_W; i++) begin
            if (par && syn == msec_pos(i)) begin
                data_fix[i] = ~data_in[i];
            end
        end
        err_single = par && !addr_hit;
        err_double = (!par && syn != '0) || addr_hit;
    end

endmodule

// File: src/msec_checker.sv
// Checked SRAM and flash arrays with SECDED protection, an unchecked test
// aperture, flash error interrupts and static sector write protection.
// Assumes one requester per port that waits for each read answer; the
// sector lock mask is static configuration held outside.
//
// Notes on behaviour
// - Check byte stored per 64-bit SRAM word.
// - SRAM reads checked: fix single, flag double.
// - Flash reads recompute and compare check bits.
// - Flash corrects single, reports double uncorrectable.
// - Flash check bits also cover the address.
// - Unchecked SRAM writes and flash programs change data, keep check bits.
// - Checked read of altered word flags error.
// - Error class follows number of flipped bits.
// - Flash errors raise interrupt or NMI.
// - Locked flash sectors refuse program and erase.
`timescale 1ns/1ns
module msec_checker
    import msec_pkg::*;
#(
    parameter int SRAM_AW  = msec_pkg::SRAM_AW_DEF,
    parameter int FLASH_AW = msec_pkg::FLASH_AW_DEF,
    parameter int SECT_W   = msec_pkg::SECT_W_DEF
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic                         sram_req,
    input  wire logic                         sram_we,
    input  wire logic                         sram_unchk,
    input  wire logic [SRAM_AW-1:0]           sram_addr,
    input  wire logic [msec_pkg::DATA_W-1:0]  sram_wdata,
    output logic                              sram_rvalid,
    output logic      [msec_pkg::DATA_W-1:0]  sram_rdata,
    output logic                              sram_err_single,
    output logic                              sram_err_double,
    input  wire logic                         flash_req,
    input  wire msec_pkg::msec_op_t           flash_op,
    input  wire logic                         flash_unchk,
    input  wire logic [FLASH_AW-1:0]          flash_addr,
    input  wire logic [msec_pkg::DATA_W-1:0]  flash_wdata,
    input  wire logic [(1<<SECT_W)-1:0]       sector_lock,
    output logic                              flash_rvalid,
    output logic      [msec_pkg::DATA_W-1:0]  flash_rdata,
    output logic                              flash_done,
    output logic                              flash_refused,
    output logic                              flash_irq,
    output logic                              flash_nmi
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Arrays carry no reset: contents are undefined until written, as in
    // real memory, and a checked read of an unwritten word may flag.
    logic [DATA_W-1:0] sram_mem  [1<<SRAM_AW];
    logic [CHK_W-1:0]  sram_chk  [1<<SRAM_AW];
    logic [DATA_W-1:0] flash_mem [1<<FLASH_AW];
    logic [CHK_W-1:0]  flash_chk [1<<FLASH_AW];

    function automatic logic [FOLD_W-1:0] fold(input logic [FLASH_AW-1:0] a);
        return FOLD_W'(a);
    endfunction

    // ------------------------------------------------------------------
    // SRAM write and read pipeline
    // ------------------------------------------------------------------
    logic              s_rd_r;
    logic              s_unchk_r;
    logic [DATA_W-1:0] s_data_r;
    logic [CHK_W-1:0]  s_chk_r;
    logic [DATA_W-1:0] s_fix;
    logic              s_single;
    logic              s_double;
    logic              s_rvalid_r;
    logic [DATA_W-1:0] s_rdata_r;
    logic              s_single_r;
    logic              s_double_r;

    always_ff @(posedge clk) begin
        if (sram_req && sram_we) begin
            sram_mem[sram_addr] <= sram_wdata;
            if (!sram_unchk) begin
                sram_chk[sram_addr] <= msec_encode(sram_wdata, '0);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_rd_r    <= 1'b0;
            s_unchk_r <= 1'b0;
            s_data_r  <= '0;
            s_chk_r   <= '0;
        end else begin
            s_rd_r    <= sram_req && !sram_we;
            s_unchk_r <= sram_unchk;
            s_data_r  <= sram_mem[sram_addr];
            s_chk_r   <= sram_chk[sram_addr];
        end
    end

    msec_secded u_sram_dec (
        .data_in    (s_data_r),
        .fold_addr  ('0),
        .chk_in     (s_chk_r),
        .data_fix   (s_fix),
        .err_single (s_single),
        .err_double (s_double)
    );

    // The unchecked aperture returns raw bits so test code can see exactly
    // what it stored; only the checked view corrects and reports.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_rvalid_r <= 1'b0;
            s_rdata_r  <= '0;
            s_single_r <= 1'b0;
            s_double_r <= 1'b0;
        end else begin
            s_rvalid_r <= s_rd_r;
            s_rdata_r  <= s_unchk_r ? s_data_r : s_fix;
            s_single_r <= s_rd_r && !s_unchk_r && s_single;
            s_double_r <= s_rd_r && !s_unchk_r && s_double;
        end
    end

    assign sram_rvalid     = s_rvalid_r;
    assign sram_rdata      = s_rdata_r;
    assign sram_err_single = s_single_r;
    assign sram_err_double = s_double_r;

    // ------------------------------------------------------------------
    // Flash program, erase and protection
    // ------------------------------------------------------------------
    logic [SECT_W-1:0] f_sect;
    logic              f_mod;
    logic              f_locked;
    logic              f_done_r;
    logic              f_refused_r;

    assign f_sect   = flash_addr[FLASH_AW-1 -: SECT_W];
    assign f_mod    = flash_req && (flash_op == MSEC_OP_PROGRAM || flash_op == MSEC_OP_ERASE);
    assign f_locked = sector_lock[f_sect];

    always_ff @(posedge clk) begin
        if (f_mod && !f_locked) begin
            if (flash_op == MSEC_OP_ERASE) begin
                flash_mem[flash_addr] <= ERASED_WORD;
                flash_chk[flash_addr] <= msec_encode(ERASED_WORD, fold(flash_addr));
            end else begin
                flash_mem[flash_addr] <= flash_wdata;
                if (!flash_unchk) begin
                    flash_chk[flash_addr] <= msec_encode(flash_wdata, fold(flash_addr));
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            f_done_r    <= 1'b0;
            f_refused_r <= 1'b0;
        end else begin
            f_done_r    <= f_mod && !f_locked;
            f_refused_r <= f_mod && f_locked;
        end
    end

    assign flash_done    = f_done_r;
    assign flash_refused = f_refused_r;

    // ------------------------------------------------------------------
    // Flash read pipeline and error signalling
    // ------------------------------------------------------------------
    logic                f_rd_r;
    logic                f_unchk_r;
    logic [FLASH_AW-1:0] f_addr_r;
    logic [DATA_W-1:0]   f_data_r;
    logic [CHK_W-1:0]    f_chk_r;
    logic [DATA_W-1:0]   f_fix;
    logic                f_single;
    logic                f_double;
    logic                f_rvalid_r;
    logic [DATA_W-1:0]   f_rdata_r;
    logic                f_irq_r;
    logic                f_nmi_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            f_rd_r    <= 1'b0;
            f_unchk_r <= 1'b0;
            f_addr_r  <= '0;
            f_data_r  <= '0;
            f_chk_r   <= '0;
        end else begin
            f_rd_r    <= flash_req && flash_op == MSEC_OP_READ;
            f_unchk_r <= flash_unchk;
            f_addr_r  <= flash_addr;
            f_data_r  <= flash_mem[flash_addr];
            f_chk_r   <= flash_chk[flash_addr];
        end
    end

    // The requested address, not the one the array decoded, feeds the
    // check, so a misdecoded fetch shows up as a mismatch.
    msec_secded u_flash_dec (
        .data_in    (f_data_r),
        .fold_addr  (fold(f_addr_r)),
        .chk_in     (f_chk_r),
        .data_fix   (f_fix),
        .err_single (f_single),
        .err_double (f_double)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            f_rvalid_r <= 1'b0;
            f_rdata_r  <= '0;
            f_irq_r    <= 1'b0;
            f_nmi_r    <= 1'b0;
        end else begin
            f_rvalid_r <= f_rd_r;
            f_rdata_r  <= f_unchk_r ? f_data_r : f_fix;
            f_irq_r    <= f_rd_r && !f_unchk_r && f_single;
            f_nmi_r    <= f_rd_r && !f_unchk_r && f_double;
        end
    end

    assign flash_rvalid = f_rvalid_r;
    assign flash_rdata  = f_rdata_r;
    assign flash_irq    = f_irq_r;
    assign flash_nmi    = f_nmi_r;

endmodule

// File: verif/msec_checker_sva.sv
// Port-level assertions for the memory error checker.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module msec_checker_sva
    import msec_pkg::*;
#(
    parameter int SRAM_AW  = 8,
    parameter int FLASH_AW = 10,
    parameter int SECT_W   = 2
) (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 sram_req,
    input wire logic                 sram_we,
    input wire logic                 sram_unchk,
    input wire logic [SRAM_AW-1:0]   sram_addr,
    input wire logic [DATA_W-1:0]    sram_wdata,
    input wire logic                 sram_rvalid,
    input wire logic [DATA_W-1:0]    sram_rdata,
    input wire logic                 sram_err_single,
    input wire logic                 sram_err_double,
    input wire logic                 flash_req,
    input wire msec_op_t             flash_op,
    input wire logic                 flash_unchk,
    input wire logic [FLASH_AW-1:0]  flash_addr,
    input wire logic [DATA_W-1:0]    flash_wdata,
    input wire logic [(1<<SECT_W)-1:0] sector_lock,
    input wire logic                 flash_rvalid,
    input wire logic [DATA_W-1:0]    flash_rdata,
    input wire logic                 flash_done,
    input wire logic                 flash_refused,
    input wire logic                 flash_irq,
    input wire logic                 flash_nmi
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    wire locked = sector_lock[flash_addr[FLASH_AW-1 -: SECT_W]];

    sequence s_sram_rd;
        sram_req && !sram_we;
    endsequence
    sequence s_flash_rd;
        flash_req && flash_op == MSEC_OP_READ;
    endsequence
    sequence s_flash_pe;
        flash_req && (flash_op == MSEC_OP_PROGRAM || flash_op == MSEC_OP_ERASE);
    endsequence

    chk_sram_rd_answer:
        assert property (s_sram_rd |-> ##2 sram_rvalid) else $error("sram answer late");
    chk_sram_rv_cause:
        assert property (sram_rvalid |-> $past(sram_req && !sram_we, 2))
        else $error("sram answer without read");
    chk_sram_err_one:
        assert property ((sram_err_single || sram_err_double) |->
                         sram_rvalid && !(sram_err_single && sram_err_double))
        else $error("sram error class bad");
    chk_unchk_quiet:
        assert property (s_sram_rd ##0 sram_unchk |-> ##2 !sram_err_single && !sram_err_double)
        else $error("unchecked read flagged");
    chk_flash_rd_answer:
        assert property (s_flash_rd |-> ##2 flash_rvalid) else $error("flash answer late");
    chk_flash_int_rv:
        assert property ((flash_irq || flash_nmi) |-> flash_rvalid && !(flash_irq && flash_nmi))
        else $error("flash interrupt outside answer");
    chk_lock_refuse:
        assert property (s_flash_pe ##0 locked |=> flash_refused && !flash_done)
        else $error("locked sector not refused");
    chk_open_done:
        assert property (s_flash_pe ##0 !locked |=> flash_done && !flash_refused)
        else $error("open sector not done");
endmodule

bind msec_checker msec_checker_sva #(.SRAM_AW(SRAM_AW), .FLASH_AW(FLASH_AW), .SECT_W(SECT_W))
    u_sva (.clk, .reset_n, .sram_req, .sram_we, .sram_unchk, .sram_addr, .sram_wdata,
           .sram_rvalid, .sram_rdata, .sram_err_single, .sram_err_double, .flash_req,
           .flash_op, .flash_unchk, .flash_addr, .flash_wdata, .sector_lock, .flash_rvalid,
           .flash_rdata, .flash_done, .flash_refused, .flash_irq, .flash_nmi);

// File: verif/msec_host.sv
// Bus master model standing for the processor or DMA side.
// Assumes the caller waits for each answer before the next request.
`timescale 1ns/1ns
module msec_host
    import msec_pkg::*;
(
    input  wire logic  clk,
    output logic       sram_req,
    output logic       sram_we,
    output logic       sram_unchk,
    output logic [7:0] sram_addr,
    output logic [63:0] sram_wdata,
    output logic       flash_req,
    output msec_op_t   flash_op,
    output logic       flash_unchk,
    output logic [9:0] flash_addr,
    output logic [63:0] flash_wdata
);
    initial begin
        {sram_req, sram_we, sram_unchk, sram_addr, sram_wdata} = '0;
        {flash_req, flash_unchk, flash_addr, flash_wdata} = '0;
        flash_op = MSEC_OP_NONE;
    end

    // A random idle gap models both prompt and slow masters. Released address
    // and data lines are inverted so stale values never look valid.
    task automatic sram(input logic we, unchk, input logic [7:0] a, input logic [63:0] d);
        repeat ($urandom_range(2)) @(posedge clk);
        @(posedge clk);
        {sram_req, sram_we, sram_unchk, sram_addr, sram_wdata} <= {1'b1, we, unchk, a, d};
        @(posedge clk);
        {sram_req, sram_addr, sram_wdata} <= {1'b0, ~a, ~d};
    endtask

    task automatic flash(input msec_op_t op, input logic unchk, input logic [9:0] a,
                         input logic [63:0] d);
        repeat ($urandom_range(2)) @(posedge clk);
        @(posedge clk);
        {flash_req, flash_op, flash_unchk, flash_addr, flash_wdata} <= {1'b1, op, unchk, a, d};
        @(posedge clk);
        {flash_req, flash_op, flash_addr, flash_wdata} <= {1'b0, MSEC_OP_NONE, ~a, ~d};
    endtask
endmodule

// File: verif/msec_checker_tb.sv
// Self-checking bench: checked and unchecked accesses, flash errors,
// erase and sector lock, compared with an associative-array model.
`timescale 1ns/1ns
module msec_checker_tb;
    import msec_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] sector_lock = 4'h0;
    logic sram_req, sram_we, sram_unchk, sram_rvalid, sram_err_single, sram_err_double;
    logic flash_req, flash_unchk, flash_rvalid, flash_done, flash_refused, flash_irq, flash_nmi;
    logic [7:0] sram_addr;
    logic [9:0] flash_addr;
    logic [63:0] sram_wdata, sram_rdata, flash_wdata, flash_rdata, w, f;
    msec_op_t flash_op;
    int n_mismatch = 0;
    int checked = 0;
    logic [63:0] fm [int];

    always #2 clk = ~clk;

    msec_checker dut (.clk, .reset_n, .sram_req, .sram_we, .sram_unchk, .sram_addr,
        .sram_wdata, .sram_rvalid, .sram_rdata, .sram_err_single, .sram_err_double,
        .flash_req, .flash_op, .flash_unchk, .flash_addr, .flash_wdata, .sector_lock,
        .flash_rvalid, .flash_rdata, .flash_done, .flash_refused, .flash_irq, .flash_nmi);
    msec_host h (.clk, .sram_req, .sram_we, .sram_unchk, .sram_addr, .sram_wdata,
        .flash_req, .flash_op, .flash_unchk, .flash_addr, .flash_wdata);

    task automatic check(input string what, input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Flags are {rvalid, single, double}; data is returned uncorrected and is not checked after a double error.
    task automatic rd(input bit fl, input int a, input logic u, input logic [63:0] e,
                      input logic [2:0] x);
        if (fl) h.flash(MSEC_OP_READ, u, a[9:0], '0);
        else h.sram(1'b0, u, a[7:0], '0);
        // The host returns on the taking edge; the answer stands one edge later.
        @(posedge clk);
        #1;
        if (x !== 3'b101) check("read data", fl ? flash_rdata : sram_rdata, e);
        check("flags", fl ? {flash_rvalid, flash_irq, flash_nmi} :
              {sram_rvalid, sram_err_single, sram_err_double}, x);
    endtask

    task automatic pe(input msec_op_t op, input logic u, input int a, input logic [63:0] d);
        logic lk;
        h.flash(op, u, a[9:0], d);
        // The lock mask is read after the taking edge, so a mask update that
        // was scheduled on the edge before the call is already in place.
        #1;
        lk = sector_lock[a[9:8]];
        check("done refused", {flash_done, flash_refused}, lk ? 2'b01 : 2'b10);
        if (!lk && !u) fm[a] = (op == MSEC_OP_ERASE) ? ERASED_WORD : d;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(5643));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        w = {$urandom, $urandom};
        for (int i = 0; i < 4; i++) begin
            h.sram(1'b1, 1'b0, 8'(i * 37), w ^ i);
            rd(0, i * 37, 0, w ^ i, 3'b100);
            pe(MSEC_OP_PROGRAM, 0, i * 200, w + i);
            rd(1, i * 200, 0, w + i, 3'b100);
        end
        $display("clean traffic done");
        for (int n = 1; n <= 2; n++) begin
            f = (64'h1 << (n * 29)) | ((n == 2) ? 64'h1 << $urandom_range(57) : 64'h0);
            h.sram(1'b1, 1'b1, 8'd0, w ^ f);
            rd(0, 0, 1, w ^ f, 3'b100);
            rd(0, 0, 0, w, n == 1 ? 3'b110 : 3'b101);
            pe(MSEC_OP_PROGRAM, 1, 0, w ^ f);
            rd(1, 0, 1, w ^ f, 3'b100);
            rd(1, 0, 0, w, n == 1 ? 3'b110 : 3'b101);
            h.sram(1'b1, 1'b0, 8'd0, w);
            pe(MSEC_OP_PROGRAM, 0, 0, w);
        end
        $display("corruption done");
        pe(MSEC_OP_ERASE, 0, 700, '0);
        rd(1, 700, 0, ERASED_WORD, 3'b100);
        @(posedge clk);
        sector_lock <= 4'b0100;
        pe(MSEC_OP_PROGRAM, 0, 700, w);
        pe(MSEC_OP_ERASE, 0, 600, '0);
        rd(1, 700, 0, fm[700], 3'b100);
        rd(1, 600, 0, fm[600], 3'b100);
        pe(MSEC_OP_PROGRAM, 0, 100, ~w);
        rd(1, 100, 0, ~w, 3'b100);
        $display("erase and lock done");
        summarize();
    end
endmodule
